// File: hdl/adcpm_ctrl.sv
// power mode control and serial result shifter of a serial sar adc
// Behaviour
// - frame fall samples input, starts conversion
// - rise edges 10..15: stay powered, abort, release
// - full conversion takes sixteen serial clocks
// - rise edges 2..9 enters power-down
// - power-down aborts and releases output promptly
// - rise before edge 2 keeps normal mode
// - power-down switches analog circuitry off
// - wake from frame fall, powered after 1us
// - waking rise before edge 10 powers down
// - hold in power-down, track on first edge
// - track mode at initial power application
// - four zeros then twelve bits, msb first
// - track again after thirteenth falling edge
`timescale 1ns/1ps
module adcpm_ctrl #(
  parameter int unsigned PWR_CYCLES = adcpm_pkg::POWER_UP_CYCLES
) (
  // clock and reset
  input  wire logic                           clock_in,
  input  wire logic                           nrst_in,
  input  wire logic                           ce_in,
  // serial link pins
  input  wire logic                           frame_n_in,
  input  wire logic                           sclk_in,
  output logic                                serial_result_out,
  output logic                                serial_result_oe_out,
  // analog core side
  input  wire logic [adcpm_pkg::DATA_BITS-1:0] sample_data_in,
  output logic                                sample_out,
  output logic                                track_out,
  output logic                                analog_on_out,
  output logic                                powered_out
);
  localparam int unsigned SHW = adcpm_pkg::LEAD_ZEROS + adcpm_pkg::DATA_BITS;

  // the wake counter must reach its target without wrapping
  if (PWR_CYCLES < 1 || PWR_CYCLES >= (1 << adcpm_pkg::PWR_CNT_W)) begin : g_bad_pwr_cycles
    $error("PWR_CYCLES out of range");
  end

  logic frame_rise;
  logic frame_fall;
  logic sclk_rise;
  logic sclk_fall;

  adcpm_sync #(.INIT(1'b1)) u_frame (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .ce_in     (ce_in),
    .pin_in    (frame_n_in),
    .level_out (),
    .rise_out  (frame_rise),
    .fall_out  (frame_fall)
  );

  // reset level matches the parked-high link clock, so release gives no false edge
  adcpm_sync #(.INIT(1'b1)) u_sclk (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .ce_in     (ce_in),
    .pin_in    (sclk_in),
    .level_out (),
    .rise_out  (sclk_rise),
    .fall_out  (sclk_fall)
  );

  adcpm_pkg::adcpm_mode_t mode_reg, mode_next;
  logic [adcpm_pkg::CNT_W-1:0]     cnt_reg, cnt_next;
  logic [SHW-1:0]                  shift_reg, shift_next;
  logic                            oe_reg, oe_next;
  logic                            dout_reg, dout_next;
  logic                            active_reg, active_next;
  logic                            track_reg, track_next;
  logic                            samp_reg, samp_next;
  logic                            first_reg, first_next;
  logic [adcpm_pkg::PWR_CNT_W-1:0] pwr_reg, pwr_next;
  logic                            aon_reg, aon_next;
  logic                            pwd_reg, pwd_next;

  // mode only changes at frame edges and when the wake count completes, so stray clocks while idle do nothing
  always_comb begin
    mode_next   = mode_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    oe_next     = oe_reg;
    dout_next   = dout_reg;
    active_next = active_reg;
    track_next  = track_reg;
    samp_next   = samp_reg;
    first_next  = first_reg;
    pwr_next    = pwr_reg;
    if (ce_in) begin
      samp_next = 1'b0;
      if (frame_fall) begin
        active_next = 1'b1;
        samp_next   = 1'b1;
        track_next  = 1'b0;
        cnt_next    = '0;
        shift_next  = {{adcpm_pkg::LEAD_ZEROS{1'b0}}, sample_data_in};
        dout_next   = 1'b0;
        oe_next     = 1'b1;
        first_next  = (mode_reg == adcpm_pkg::ADCPM_DOWN);
        if (mode_reg == adcpm_pkg::ADCPM_DOWN) begin
          mode_next = adcpm_pkg::ADCPM_WAKING;
          pwr_next  = '0;
        end
      end else if (frame_rise && active_reg) begin
        active_next = 1'b0;
        oe_next     = 1'b0;
        track_next  = 1'b1;
        if (mode_reg == adcpm_pkg::ADCPM_WAKING) begin
          if (cnt_reg < adcpm_pkg::KEEP_EDGES) begin
            mode_next  = adcpm_pkg::ADCPM_DOWN;
            track_next = 1'b0;
          end
        end else if (cnt_reg >= adcpm_pkg::GLITCH_EDGES && cnt_reg < adcpm_pkg::KEEP_EDGES) begin
          mode_next  = adcpm_pkg::ADCPM_DOWN;
          track_next = 1'b0;
        end
      end else if (active_reg) begin
        if ((sclk_rise || sclk_fall) && first_reg) begin
          first_next = 1'b0;
          track_next = 1'b1;
        end
        if (sclk_fall && cnt_reg < adcpm_pkg::FRAME_EDGES) begin
          cnt_next   = cnt_reg + 1'b1;
          dout_next  = shift_reg[SHW-2];
          shift_next = {shift_reg[SHW-2:0], 1'b0};
          if (cnt_reg == adcpm_pkg::FRAME_EDGES - 1) begin
            oe_next     = 1'b0;
            active_next = 1'b0;
          end
        end
        if (sclk_rise && cnt_reg == adcpm_pkg::TRACK_EDGES) begin
          track_next = 1'b1;
        end
      end
      if (mode_reg == adcpm_pkg::ADCPM_WAKING && pwr_reg < PWR_CYCLES[adcpm_pkg::PWR_CNT_W-1:0]) begin
        pwr_next = pwr_reg + 1'b1;
      end
      if (mode_reg == adcpm_pkg::ADCPM_WAKING && !active_reg && !frame_fall
          && pwr_reg >= PWR_CYCLES[adcpm_pkg::PWR_CNT_W-1:0]) begin
        mode_next = adcpm_pkg::ADCPM_NORMAL;
      end
    end
    // decoded from the next mode so the power flags come from flops yet move with the mode
    aon_next = (mode_next != adcpm_pkg::ADCPM_DOWN);
    pwd_next = (mode_next == adcpm_pkg::ADCPM_NORMAL);
  end

  // reset comes up in normal mode with the hold released, matching power-on tracking
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg   <= adcpm_pkg::ADCPM_NORMAL;
      cnt_reg    <= '0;
      shift_reg  <= '0;
      oe_reg     <= 1'b0;
      dout_reg   <= 1'b0;
      active_reg <= 1'b0;
      track_reg  <= 1'b1;
      samp_reg   <= 1'b0;
      first_reg  <= 1'b0;
      pwr_reg    <= '0;
      aon_reg    <= 1'b1;
      pwd_reg    <= 1'b1;
    end else begin
      mode_reg   <= mode_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      oe_reg     <= oe_next;
      dout_reg   <= dout_next;
      active_reg <= active_next;
      track_reg  <= track_next;
      samp_reg   <= samp_next;
      first_reg  <= first_next;
      pwr_reg    <= pwr_next;
      aon_reg    <= aon_next;
      pwd_reg    <= pwd_next;
    end
  end

  assign serial_result_out    = dout_reg;
  assign serial_result_oe_out = oe_reg;
  assign sample_out           = samp_reg;
  assign track_out            = track_reg;
  assign analog_on_out        = aon_reg;
  assign powered_out          = pwd_reg;

  property p_down_on_short;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_rise && active_reg && mode_reg == adcpm_pkg::ADCPM_NORMAL
       && cnt_reg >= 2 && cnt_reg < 10) |=> (mode_reg == adcpm_pkg::ADCPM_DOWN);
  endproperty
  a_down_on_short: assert property (p_down_on_short) else $error("no power-down on short frame");

  property p_glitch_keeps;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_rise && active_reg && mode_reg == adcpm_pkg::ADCPM_NORMAL && cnt_reg < 2)
      |=> (mode_reg == adcpm_pkg::ADCPM_NORMAL);
  endproperty
  a_glitch_keeps: assert property (p_glitch_keeps) else $error("glitch frame powered down");

  property p_long_keeps;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_rise && active_reg && mode_reg == adcpm_pkg::ADCPM_NORMAL && cnt_reg >= 10)
      |=> (mode_reg == adcpm_pkg::ADCPM_NORMAL && !oe_reg);
  endproperty
  a_long_keeps: assert property (p_long_keeps) else $error("abort after edge ten misbehaved");

  property p_release;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_rise && active_reg) |=> !serial_result_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("output not released at frame rise");

  property p_wake_abort;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_rise && active_reg && mode_reg == adcpm_pkg::ADCPM_WAKING && cnt_reg < 10)
      |=> (mode_reg == adcpm_pkg::ADCPM_DOWN && !analog_on_out);
  endproperty
  a_wake_abort: assert property (p_wake_abort) else $error("short wake did not power down");

  property p_wake_start;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_fall && mode_reg == adcpm_pkg::ADCPM_DOWN) |=> (analog_on_out && !track_out);
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wake not started at frame fall");

  property p_sixteen;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && sclk_fall && active_reg && !frame_rise && !frame_fall && cnt_reg == 15)
      |=> (cnt_reg == 16 && !oe_reg);
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("no release on sixteenth edge");

  property p_start;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && frame_fall) |=> (sample_out && serial_result_oe_out && !serial_result_out && cnt_reg == 0);
  endproperty
  a_start: assert property (p_start) else $error("conversion start wrong");

  property p_track13;
    @(posedge clock_in) disable iff (!nrst_in)
      (ce_in && sclk_rise && active_reg && !frame_rise && !frame_fall && cnt_reg == 13) |=> track_out;
  endproperty
  a_track13: assert property (p_track13) else $error("no track after edge thirteen");

  property p_hold_down;
    @(posedge clock_in) disable iff (!nrst_in)
      (mode_reg == adcpm_pkg::ADCPM_DOWN && $stable(mode_reg)) |-> !track_out;
  endproperty
  a_hold_down: assert property (p_hold_down) else $error("tracking while powered down");
endmodule

// File: hdl/adcpm_pkg.sv
// constants and types for the serial adc power mode control block
package adcpm_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned DATA_BITS        = 12;
  localparam int unsigned LEAD_ZEROS       = 4;
  localparam int unsigned FRAME_EDGES      = 16;
  localparam int unsigned GLITCH_EDGES     = 2;
  localparam int unsigned KEEP_EDGES       = 10;
  localparam int unsigned TRACK_EDGES      = 13;
  localparam int unsigned CNT_W            = 5;
  localparam int unsigned POWER_UP_TIME_NS = 1000;
  localparam int unsigned POWER_UP_CYCLES  = (POWER_UP_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PWR_CNT_W        = 8;
  localparam int unsigned OUTPUT_RELEASE_DELAY_NS = 35;
  localparam int unsigned QUIET_GAP_TIME_NS       = 60;
  typedef enum logic [1:0] {
    ADCPM_NORMAL,
    ADCPM_DOWN,
    ADCPM_WAKING
  } adcpm_mode_t;
endpackage

// File: hdl/adcpm_sync.sv
// two flip-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module adcpm_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  // pin in, settled level and edges out
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = ce_in ? pin_in : meta_reg;
    sync_next = ce_in ? meta_reg : sync_reg;
    last_next = ce_in ? sync_reg : last_reg;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      last_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = ce_in & sync_reg & ~last_reg;
  assign fall_out  = ce_in & ~sync_reg & last_reg;
endmodule

// File: sim/adcpm_host.sv
// host serial port model: drives frame and link clock, captures the result
`timescale 1ns/1ps
module adcpm_host (
  // clock
  input  wire logic clock_in,
  // link and observed pins
  input  wire logic serial_result_in,
  input  wire logic oe_in,
  input  wire logic track_in,
  input  wire logic aon_in,
  output logic      frame_n_out,
  output logic      sclk_out
);
  logic [15:0] word;
  logic [16:0] trk;
  logic [16:0] aon;
  logic [16:0] oe;
  initial begin
    frame_n_out = 1'b1;
    sclk_out    = 1'b1; // link clock parked high outside frames
  end
  // frame with n falling edges, 8 clocks a half period gives 160 ns
  task automatic frame(input int n);
    word        <= 16'h0000;
    frame_n_out <= 1'b0;
    for (int k = 1; k <= n; k++) begin
      repeat (8) @(posedge clock_in);
      // a released output reads back inverted, so an early release spoils the word
      word[16-k] <= oe_in ? serial_result_in : ~serial_result_in;
      trk[k]     <= track_in;
      aon[k]     <= aon_in;
      oe[k]      <= oe_in;
      sclk_out   <= 1'b0;
      repeat (8) @(posedge clock_in);
      sclk_out <= 1'b1;
    end
    repeat (4) @(posedge clock_in);
    frame_n_out <= 1'b1;
    // gap well past the quiet time, so release delay never overlaps it
    repeat (20) @(posedge clock_in);
  endtask
endmodule

// File: sim/adcpm_ctrl_tb_top.sv
// self-checking testbench for the serial adc power mode control block
`timescale 1ns/1ps
module adcpm_ctrl_tb_top;
  logic                              clock_in;
  logic                              nrst_in;
  logic                              ce_in;
  logic                              frame_n_in;
  logic                              sclk_in;
  logic                              serial_result_out;
  logic                              serial_result_oe_out;
  logic [adcpm_pkg::DATA_BITS-1:0]   sample_data_in;
  logic                              sample_out;
  logic                              track_out;
  logic                              analog_on_out;
  logic                              powered_out;
  logic                              down;
  int                                num_errors;
  int                                n_tests;
  int                                n_samp = 0;

  adcpm_ctrl uut (.clock_in, .nrst_in, .ce_in, .frame_n_in, .sclk_in, .serial_result_out, .serial_result_oe_out,
                  .sample_data_in, .sample_out, .track_out, .analog_on_out, .powered_out);
  adcpm_host host (.clock_in, .serial_result_in(serial_result_out), .oe_in(serial_result_oe_out),
                   .track_in(track_out), .aon_in(analog_on_out), .frame_n_out(frame_n_in), .sclk_out(sclk_in));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) if (sample_out === 1'b1) n_samp <= n_samp + 1;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // analog power after a frame of n falls, from power-down or not
  function automatic logic exp_on(input int n, input logic dn);
    if (dn) return n >= 10;
    return !(n >= 2 && n <= 9);
  endfunction

  function automatic logic [15:0] exp_word(input logic [11:0] d);
    return {4'h0, d};
  endfunction

  task automatic run(input int n);
    int   s0;
    logic on;
    s0 = n_samp;
    on = exp_on(n, down);
    host.frame(n);
    if (!down) chk(16'(n_samp - s0), 16'h0001);
    if (down && n >= 2) chk(16'(host.trk[2]), 16'h0001);
    if (down && n >= 1) chk(16'(host.aon[1]), 16'h0001);
    chk(16'(analog_on_out), 16'(on));
    chk(16'(powered_out), 16'(on));
    chk(16'(serial_result_oe_out), 16'h0000);
    if (!on) chk(16'(track_out), 16'h0000);
    down = !on;
  endtask

  // a whole frame while the clock enable is low must leave every state untouched
  task automatic frozen(input int n);
    int s0;
    s0 = n_samp;
    ce_in <= 1'b0;
    host.frame(n);
    chk(16'(n_samp - s0), 16'h0000);
    chk(16'(analog_on_out), 16'(!down));
    chk(16'(serial_result_oe_out), 16'h0000);
    ce_in <= 1'b1;
  endtask

  task automatic conv(input logic [11:0] d);
    sample_data_in <= d;
    @(posedge clock_in);
    run(16);
    chk(host.word, exp_word(d));
    chk(16'(host.trk[13]), 16'h0000);
    chk(16'(host.trk[14]), 16'h0001);
    chk(16'(host.oe[16]), 16'h0001);
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    nrst_in        = 1'b0;
    ce_in          = 1'b1;
    sample_data_in = '0;
    down           = 1'b0;
    num_errors     = 0;
    n_tests        = 0;
    void'($urandom(27154));
    repeat (20) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk(16'(track_out), 16'h0001);
    chk(16'(powered_out), 16'h0001);
    chk(16'(serial_result_oe_out), 16'h0000);
    conv(12'h000);
    conv(12'hfff);
    // every frame length, then a refused and a real wake-up where powered down
    for (int n = 0; n <= 16; n++) begin
      run(n);
      if (n == 5) frozen(12);
      if (down) begin
        run(9);
        run(10 + $urandom_range(6));
      end
      conv(12'($urandom));
    end
    // reset in mid-run from power-down must come back tracking with the analog circuitry on
    run(3);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk(16'(track_out), 16'h0001);
    chk(16'(analog_on_out), 16'h0001);
    down = 1'b0;
    conv(12'($urandom));
    report_and_stop();
  end

  // the tests need about 12000 clocks, so a hang is caught well before the run grows long
  initial begin
    repeat (30000) @(posedge clock_in);
    num_errors++;
    report_and_stop();
  end
endmodule
